/* logic/hrf_defines.svh */
// Function
// RULE1: Record opens with file-type constant, then capture time, then port index, 4 bytes each.
// RULE2: A 256-byte zero-terminated device identifier follows the port index.
// RULE3: Fixed header values are right-justified with leading zero padding.
// RULE4: Capture time holds epoch seconds at the moment the record is written.
// RULE5: A 4-byte symmetry field follows the identifier: false 256 bins, true 255.
// RULE6: Even symmetry reports bins 0 through 255 as valid hit data.
// RULE7: Even symmetry bin centre is its two's-complement value plus one half.
// RULE8: Odd symmetry leaves bin 0 unused, valid data only in bins 1 to 255.
// RULE9: Odd symmetry bin centre sits exactly on its two's-complement value.
// RULE10: Dwell length field then 1 to 4096 dwell values of 4 bytes.
// RULE11: When all dwell counts match, report a single dwell value.
// RULE12: Hit length field then 1 to 4096 hit values of 4 bytes.
// RULE13: Odd symmetry outputs exactly 255 hit entries.
// RULE14: Every dwell and hit value is stored as a 32-bit integer.
// RULE15: Name changes while busy are refused with a rejected-write error.
// RULE16: Empty name at test start gets a generated default, readable afterwards.
// RULE17: Requester sets a meaningful or empty name before each new test.
// RULE18: Clearing capture enable stops collection and produces the record.
// RULE19: Timeout expiry clears enable, keeps data, sets result available.
// RULE20: Multi-byte fields are sent most significant byte first.
// RULE21: Each length field equals emitted entries times four.
`ifndef HRF_DEFINES_SVH
`define HRF_DEFINES_SVH

`define HRF_FILE_TYPE 32'h504E4D68
`define HRF_DEFAULT_PREFIX 32'h48495354

`define HRF_OFS_CONTROL 12'h000
`define HRF_OFS_STATUS 12'h004
`define HRF_OFS_TIMEOUT 12'h008
`define HRF_OFS_EPOCH 12'h00C
`define HRF_OFS_PORT 12'h010
`define HRF_OFS_PTR 12'h014
`define HRF_OFS_DATA 12'h018
`define HRF_OFS_WORDS 12'h01C
`define HRF_WIN_NAME 4'h1
`define HRF_WIN_ID 4'h2

`define HRF_CTL_ENABLE 0
`define HRF_CTL_ODD 1
`define HRF_STS_REJECT 4
`define HRF_STS_UNIFORM 5

`define HRF_TIMEOUT_RESET 16'h0708

`define HRF_W_TIME 10'h001
`define HRF_W_PORT 10'h002
`define HRF_W_ID 10'h003
`define HRF_W_SYM 10'h043
`define HRF_W_DLEN 10'h044
`define HRF_W_DWELL 10'h045

`define HRF_SECOND_NS 1000000000
`define HRF_CLK_NS 40

`endif

/* logic/hrf_pkg.sv */
package hrf_pkg;
	typedef enum logic [1:0] {
		HRF_ST_IDLE = 2'b00,
		HRF_ST_CAPTURE = 2'b01,
		HRF_ST_SCAN = 2'b10,
		HRF_ST_READY = 2'b11
	} hrf_state_type;
	typedef enum logic [1:0] {
		HRF_MEAS_INACTIVE = 2'b00,
		HRF_MEAS_BUSY = 2'b01,
		HRF_MEAS_AVAILABLE = 2'b10
	} hrf_meas_type;
endpackage

/* logic/hrf_name_if.sv */
`timescale 1ns/1ps
interface hrf_name_if;
	logic wr;
	logic busy;
	logic start;
	logic rejected;
	logic [5:0] index;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] epoch;
	modport store(input wr, busy, start, index, wdata, epoch, output rdata, rejected);
	modport ctrl(output wr, busy, start, index, wdata, epoch, input rdata, rejected);
endinterface

/* logic/hrf_name.sv */
`timescale 1ns/1ps
`include "hrf_defines.svh"
module hrf_name (
	input wire logic clk,
	input wire logic rst,
	hrf_name_if.store nif
);
	import hrf_pkg::*;

	logic [31:0] mem [64];
	logic [31:0] word_next [64];
	logic [31:0] dflt [4];
	logic load_default;
	logic wr_ok;

	function automatic logic [7:0] hex_char(input logic [3:0] d);
		hex_char = (d < 4'hA) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
	endfunction

	// Default text is prefix, underscore and the epoch in hex
	assign dflt[0] = `HRF_DEFAULT_PREFIX;
	assign dflt[1] = {8'h5F, hex_char(nif.epoch[31:28]), hex_char(nif.epoch[27:24]),
		hex_char(nif.epoch[23:20])};
	assign dflt[2] = {hex_char(nif.epoch[19:16]), hex_char(nif.epoch[15:12]),
		hex_char(nif.epoch[11:8]), hex_char(nif.epoch[7:4])};
	assign dflt[3] = {hex_char(nif.epoch[3:0]), 24'h000000};

	assign load_default = nif.start && (mem[0][31:24] == 8'h00); // see RULE16
	assign wr_ok = nif.wr && !nif.busy && !nif.start;
	assign nif.rejected = nif.wr && nif.busy; // see RULE15
	assign nif.rdata = mem[nif.index];

	for (genvar i = 0; i < 64; i++) begin : g_word
		always_comb begin
			word_next[i] = mem[i];
			if (load_default) begin
				word_next[i] = (i < 4) ? dflt[i % 4] : 32'h00000000; // see RULE16
			end else if (wr_ok && nif.index == 6'(i)) begin
				word_next[i] = nif.wdata;
			end
		end
		always_ff @(posedge clk) begin
			if (rst) begin
				mem[i] <= 32'h00000000;
			end else begin
				mem[i] <= word_next[i];
			end
		end
	end
endmodule

/* logic/hrf_formatter.sv */
`timescale 1ns/1ps
`include "hrf_defines.svh"
module hrf_formatter #(
	parameter int SEC_CYCLES = `HRF_SECOND_NS / `HRF_CLK_NS
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic acc_capture_enable,
	output logic acc_clear,
	output logic acc_odd_symmetry,
	output logic [7:0] acc_bin_index,
	input wire logic [31:0] acc_dwell_count,
	input wire logic [31:0] acc_hit_count,
	output hrf_pkg::hrf_meas_type measurement_state,
	output logic rejected_write_error
);
	import hrf_pkg::*;

	hrf_name_if nif();

	hrf_name u_name (
		.clk(clk),
		.rst(rst),
		.nif(nif)
	);

	hrf_state_type state_reg, state_next;
	logic ack_reg, ack_next;
	logic [31:0] rdata_reg, rdata_next;
	logic odd_reg, odd_next;
	logic uniform_reg, uniform_next;
	logic reject_reg, reject_next;
	logic clear_reg, clear_next;
	logic [15:0] timeout_reg, timeout_next;
	logic [15:0] tmo_cnt_reg, tmo_cnt_next;
	logic [31:0] sec_cnt_reg, sec_cnt_next;
	logic [31:0] epoch_reg, epoch_next;
	logic [31:0] cap_time_reg, cap_time_next;
	logic [31:0] port_reg, port_next;
	logic [31:0] first_dwell_reg, first_dwell_next;
	logic [9:0] ptr_reg, ptr_next;
	logic [7:0] bin_reg, bin_next;
	logic [31:0] id_mem [64];

	logic [11:0] byte_addr;
	logic req, wr_acc, rd_acc, busy, sec_tick, start, stop;
	logic [8:0] dwell_n, hit_n;
	logic [9:0] hit_len_idx, hit_base, total;
	logic [7:0] first_bin;
	logic [31:0] word_val, read_mux;

	assign byte_addr = {avs_address, 2'b00};
	assign req = avs_read || avs_write;
	// One wait cycle for every access keeps read data from a flop
	assign avs_waitrequest = req && !ack_reg;
	assign wr_acc = avs_write && ack_reg;
	assign rd_acc = avs_read && ack_reg;
	assign busy = (state_reg == HRF_ST_CAPTURE) || (state_reg == HRF_ST_SCAN);
	assign sec_tick = (sec_cnt_reg == 32'(SEC_CYCLES - 1));
	assign first_bin = odd_reg ? 8'h01 : 8'h00; // see RULE8

	// Record geometry
	assign hit_n = odd_reg ? 9'h0FF : 9'h100; // see RULE13
	assign dwell_n = uniform_reg ? 9'h001 : hit_n; // see RULE11
	assign hit_len_idx = `HRF_W_DWELL + {1'b0, dwell_n};
	assign hit_base = hit_len_idx + 10'h001;
	assign total = hit_base + {1'b0, hit_n};

	function automatic logic [7:0] bin_of(input logic [9:0] w, input logic [9:0] hb,
		input logic odd, input logic uni);
		logic [9:0] k;
		k = 10'h000;
		bin_of = 8'h00;
		if (w >= hb) begin
			k = w - hb;
			bin_of = odd ? 8'(k + 10'h001) : k[7:0]; // see RULE6
		end else if (w >= `HRF_W_DWELL) begin
			k = w - `HRF_W_DWELL;
			if (uni) begin
				bin_of = odd ? 8'h01 : 8'h00;
			end else begin
				bin_of = odd ? 8'(k + 10'h001) : k[7:0];
			end
		end
	endfunction

	// Words are big-endian on the bus, so byte 0 of a field is bits 31:24
	always_comb begin
		word_val = 32'h00000000;
		if (state_reg != HRF_ST_READY || ptr_reg >= total) begin
			word_val = 32'h00000000;
		end else if (ptr_reg == 10'h000) begin
			word_val = `HRF_FILE_TYPE; // see RULE1
		end else if (ptr_reg == `HRF_W_TIME) begin
			word_val = cap_time_reg; // see RULE3
		end else if (ptr_reg == `HRF_W_PORT) begin
			word_val = port_reg; // see RULE1
		end else if (ptr_reg < `HRF_W_SYM) begin
			word_val = id_mem[6'(ptr_reg - `HRF_W_ID)]; // see RULE2
		end else if (ptr_reg == `HRF_W_SYM) begin
			word_val = {31'h00000000, odd_reg}; // see RULE5
		end else if (ptr_reg == `HRF_W_DLEN) begin
			word_val = {21'h000000, dwell_n, 2'b00}; // see RULE21
		end else if (ptr_reg < hit_len_idx) begin
			word_val = acc_dwell_count; // see RULE10
		end else if (ptr_reg == hit_len_idx) begin
			word_val = {21'h000000, hit_n, 2'b00}; // see RULE12
		end else begin
			word_val = acc_hit_count; // see RULE14
		end
	end

	always_comb begin
		read_mux = 32'h00000000;
		if (byte_addr == `HRF_OFS_CONTROL) begin
			read_mux = {30'h00000000, odd_reg, state_reg == HRF_ST_CAPTURE};
		end else if (byte_addr == `HRF_OFS_STATUS) begin
			read_mux = {26'h0000000, uniform_reg, reject_reg, 2'b00, measurement_state};
		end else if (byte_addr == `HRF_OFS_TIMEOUT) begin
			read_mux = {16'h0000, timeout_reg};
		end else if (byte_addr == `HRF_OFS_EPOCH) begin
			read_mux = epoch_reg;
		end else if (byte_addr == `HRF_OFS_PORT) begin
			read_mux = port_reg;
		end else if (byte_addr == `HRF_OFS_PTR) begin
			read_mux = {22'h000000, ptr_reg};
		end else if (byte_addr == `HRF_OFS_DATA) begin
			read_mux = word_val; // see RULE20
		end else if (byte_addr == `HRF_OFS_WORDS) begin
			read_mux = {22'h000000, total};
		end else if (byte_addr[11:8] == `HRF_WIN_NAME) begin
			read_mux = nif.rdata; // see RULE16
		end else if (byte_addr[11:8] == `HRF_WIN_ID) begin
			read_mux = id_mem[avs_address[5:0]];
		end
	end

	assign nif.wr = wr_acc && (byte_addr[11:8] == `HRF_WIN_NAME);
	assign nif.busy = busy;
	assign nif.index = avs_address[5:0];
	assign nif.wdata = avs_writedata;
	assign nif.epoch = epoch_reg;
	assign nif.start = start;

	always_comb begin
		state_next = state_reg;
		ack_next = req && !ack_reg;
		rdata_next = rdata_reg;
		odd_next = odd_reg;
		uniform_next = uniform_reg;
		clear_next = 1'b0;
		timeout_next = timeout_reg;
		tmo_cnt_next = tmo_cnt_reg;
		sec_cnt_next = sec_tick ? 32'h00000000 : sec_cnt_reg + 32'h00000001;
		epoch_next = sec_tick ? epoch_reg + 32'h00000001 : epoch_reg;
		cap_time_next = cap_time_reg;
		port_next = port_reg;
		first_dwell_next = first_dwell_reg;
		ptr_next = ptr_reg;
		start = 1'b0;
		stop = 1'b0;
		if (req && !ack_reg && avs_read) begin
			rdata_next = read_mux;
		end
		if (wr_acc) begin
			if (byte_addr == `HRF_OFS_CONTROL) begin
				if (!busy) begin
					odd_next = avs_writedata[`HRF_CTL_ODD];
					start = avs_writedata[`HRF_CTL_ENABLE];
				end else if (state_reg == HRF_ST_CAPTURE && !avs_writedata[`HRF_CTL_ENABLE]) begin
					stop = 1'b1; // see RULE18
				end
			end else if (byte_addr == `HRF_OFS_TIMEOUT) begin
				timeout_next = avs_writedata[15:0];
				tmo_cnt_next = 16'h0000;
			end else if (byte_addr == `HRF_OFS_EPOCH) begin
				epoch_next = avs_writedata;
			end else if (byte_addr == `HRF_OFS_PORT) begin
				port_next = avs_writedata;
			end else if (byte_addr == `HRF_OFS_PTR) begin
				ptr_next = avs_writedata[9:0];
			end
		end
		if (rd_acc && byte_addr == `HRF_OFS_DATA && state_reg == HRF_ST_READY && ptr_reg < total) begin
			ptr_next = ptr_reg + 10'h001;
		end
		// Zero timeout means run until stopped
		if (state_reg == HRF_ST_CAPTURE && sec_tick && timeout_reg != 16'h0000) begin
			tmo_cnt_next = tmo_cnt_reg + 16'h0001;
			if (tmo_cnt_reg + 16'h0001 >= timeout_reg) begin
				stop = 1'b1; // see RULE19
			end
		end
		bin_next = bin_of(ptr_next, hit_base, odd_reg, uniform_reg);
		case (state_reg)
			HRF_ST_IDLE, HRF_ST_READY: begin
				if (start) begin
					state_next = HRF_ST_CAPTURE;
					clear_next = 1'b1;
					tmo_cnt_next = 16'h0000;
				end
			end
			HRF_ST_CAPTURE: begin
				if (stop) begin
					state_next = HRF_ST_SCAN; // see RULE18
					cap_time_next = epoch_reg; // see RULE4
					uniform_next = 1'b1;
					bin_next = first_bin;
				end
			end
			HRF_ST_SCAN: begin
				// Scan compares every used bin against the first one
				bin_next = bin_reg + 8'h01;
				if (bin_reg == first_bin) begin
					first_dwell_next = acc_dwell_count;
				end else if (acc_dwell_count != first_dwell_reg) begin
					uniform_next = 1'b0; // see RULE11
				end
				if (bin_reg == 8'hFF) begin
					state_next = HRF_ST_READY; // see RULE19
					ptr_next = 10'h000;
					bin_next = 8'h00;
				end
			end
			default: begin
				state_next = HRF_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= HRF_ST_IDLE;
			ack_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			odd_reg <= 1'b0;
			uniform_reg <= 1'b0;
			clear_reg <= 1'b0;
			timeout_reg <= `HRF_TIMEOUT_RESET;
			tmo_cnt_reg <= 16'h0000;
			sec_cnt_reg <= 32'h00000000;
			epoch_reg <= 32'h00000000;
			cap_time_reg <= 32'h00000000;
			port_reg <= 32'h00000000;
			first_dwell_reg <= 32'h00000000;
			ptr_reg <= 10'h000;
			bin_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			ack_reg <= ack_next;
			rdata_reg <= rdata_next;
			odd_reg <= odd_next;
			uniform_reg <= uniform_next;
			clear_reg <= clear_next;
			timeout_reg <= timeout_next;
			tmo_cnt_reg <= tmo_cnt_next;
			sec_cnt_reg <= sec_cnt_next;
			epoch_reg <= epoch_next;
			cap_time_reg <= cap_time_next;
			port_reg <= port_next;
			first_dwell_reg <= first_dwell_next;
			ptr_reg <= ptr_next;
			bin_reg <= bin_next;
		end
	end

	// Set wins over clear, so a refusal in the clearing cycle survives
	assign reject_next = (reject_reg && !(wr_acc && byte_addr == `HRF_OFS_STATUS
		&& avs_writedata[`HRF_STS_REJECT])) || nif.rejected; // see RULE15
	always_ff @(posedge clk) begin
		if (rst) begin
			reject_reg <= 1'b0;
		end else begin
			reject_reg <= reject_next;
		end
	end

	// Identifier is frozen while a measurement runs
	for (genvar i = 0; i < 64; i++) begin : g_id
		always_ff @(posedge clk) begin
			if (rst) begin
				id_mem[i] <= 32'h00000000;
			end else if (wr_acc && !busy && byte_addr[11:8] == `HRF_WIN_ID
				&& avs_address[5:0] == 6'(i)) begin
				id_mem[i] <= avs_writedata; // see RULE2
			end
		end
	end

	assign avs_readdata = rdata_reg;
	assign acc_capture_enable = (state_reg == HRF_ST_CAPTURE);
	assign acc_clear = clear_reg;
	assign acc_odd_symmetry = odd_reg; // see RULE9
	assign acc_bin_index = bin_reg; // see RULE7
	assign rejected_write_error = reject_reg;
	assign measurement_state = busy ? HRF_MEAS_BUSY :
		(state_reg == HRF_ST_READY) ? HRF_MEAS_AVAILABLE : HRF_MEAS_INACTIVE;

	property p_file_type;
		@(posedge clk) disable iff (rst)
		rd_acc && byte_addr == `HRF_OFS_DATA && state_reg == HRF_ST_READY && ptr_reg == 10'h000
		|-> avs_readdata == 32'h504E4D68;
	endproperty
	a_file_type: assert property (p_file_type) else $error("file type word wrong"); // see RULE1

	property p_time;
		@(posedge clk) disable iff (rst)
		rd_acc && byte_addr == `HRF_OFS_DATA && state_reg == HRF_ST_READY && ptr_reg == 10'h001
		|-> avs_readdata == cap_time_reg;
	endproperty
	a_time: assert property (p_time) else $error("capture time word wrong"); // see RULE4

	property p_sym;
		@(posedge clk) disable iff (rst)
		rd_acc && byte_addr == `HRF_OFS_DATA && state_reg == HRF_ST_READY && ptr_reg == 10'h043
		|-> avs_readdata == {31'h00000000, odd_reg};
	endproperty
	a_sym: assert property (p_sym) else $error("symmetry word wrong"); // see RULE5

	property p_dwell_len;
		@(posedge clk) disable iff (rst)
		rd_acc && byte_addr == `HRF_OFS_DATA && state_reg == HRF_ST_READY && ptr_reg == 10'h044
		|-> avs_readdata == (uniform_reg ? 32'h4 : (odd_reg ? 32'h3FC : 32'h400));
	endproperty
	a_dwell_len: assert property (p_dwell_len) else $error("dwell length wrong"); // see RULE21

	property p_hit_len;
		@(posedge clk) disable iff (rst)
		rd_acc && byte_addr == `HRF_OFS_DATA && state_reg == HRF_ST_READY
		&& ptr_reg == hit_len_idx && odd_reg |-> avs_readdata == 32'h3FC && total - hit_base == 10'h0FF;
	endproperty
	a_hit_len: assert property (p_hit_len) else $error("odd hit length wrong"); // see RULE13

	property p_odd_bin;
		@(posedge clk) disable iff (rst)
		state_reg == HRF_ST_READY && odd_reg && ptr_reg >= hit_base && ptr_reg < total
		|-> acc_bin_index != 8'h00;
	endproperty
	a_odd_bin: assert property (p_odd_bin) else $error("odd record used bin zero"); // see RULE8

	property p_stop;
		@(posedge clk) disable iff (rst)
		state_reg == HRF_ST_CAPTURE && wr_acc && byte_addr == `HRF_OFS_CONTROL
		&& !avs_writedata[0] |=> !acc_capture_enable && state_reg == HRF_ST_SCAN;
	endproperty
	a_stop: assert property (p_stop) else $error("disable did not stop capture"); // see RULE18

	property p_timeout;
		@(posedge clk) disable iff (rst)
		state_reg == HRF_ST_CAPTURE && sec_tick && timeout_reg != 16'h0000
		&& tmo_cnt_reg + 16'h0001 >= timeout_reg
		|=> !acc_capture_enable ##[255:256] measurement_state == HRF_MEAS_AVAILABLE;
	endproperty
	a_timeout: assert property (p_timeout) else $error("timeout did not finish record"); // see RULE19

	property p_reject;
		@(posedge clk) disable iff (rst)
		wr_acc && byte_addr[11:8] == `HRF_WIN_NAME && busy |=> rejected_write_error;
	endproperty
	a_reject: assert property (p_reject) else $error("busy name write not refused"); // see RULE15
endmodule

/* tb/hrf_acc_model.sv */
`timescale 1ns/1ps
module hrf_acc_model (
	input wire logic [7:0] acc_bin_index,
	input wire logic uniform,
	output logic [31:0] acc_dwell_count,
	output logic [31:0] acc_hit_count
);
	// Counts are read combinationally from the bin index, like the real array
	// Bin 0 differs in uniform mode so an odd scan must skip it to see a match
	always_comb begin
		if (uniform) begin
			acc_dwell_count = (acc_bin_index == 8'h00) ? 32'h0BAD0000 : 32'h00C0FFEE;
		end else begin
			acc_dwell_count = 32'h80000000 | {24'h000000, acc_bin_index};
		end
		acc_hit_count = {acc_bin_index, 8'h5A, ~acc_bin_index, acc_bin_index};
	end
endmodule

/* tb/histogram_result_file_formatter_tb.sv */
`timescale 1ns/1ps
`include "hrf_defines.svh"
module histogram_result_file_formatter_tb;
	import hrf_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [9:0] avs_address = 10'h000;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic acc_capture_enable;
	logic acc_clear;
	logic acc_odd_symmetry;
	logic [7:0] acc_bin_index;
	logic [31:0] acc_dwell_count;
	logic [31:0] acc_hit_count;
	hrf_meas_type measurement_state;
	logic rejected_write_error;
	logic uniform = 1'b0;
	logic [31:0] rd;
	logic [31:0] e0;
	logic [31:0] e1;
	int failures = 0;
	int samples_checked = 0;

	hrf_formatter #(.SEC_CYCLES(20)) dut_u (
		.clk(clk),
		.rst(rst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.acc_capture_enable(acc_capture_enable),
		.acc_clear(acc_clear),
		.acc_odd_symmetry(acc_odd_symmetry),
		.acc_bin_index(acc_bin_index),
		.acc_dwell_count(acc_dwell_count),
		.acc_hit_count(acc_hit_count),
		.measurement_state(measurement_state),
		.rejected_write_error(rejected_write_error)
	);

	hrf_acc_model acc_u (
		.acc_bin_index(acc_bin_index),
		.uniform(uniform),
		.acc_dwell_count(acc_dwell_count),
		.acc_hit_count(acc_hit_count)
	);

	initial begin
		forever #20 clk = ~clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Waitrequest and read data are taken at the rising edge that completes the transfer
	task automatic wait_ack();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			failures++;
			$display("BAD waitrequest expected 0 seen %b", avs_waitrequest);
		end
		rd = avs_readdata;
	endtask

	task automatic bus_write(input logic [11:0] ofs, input logic [31:0] d);
		avs_address <= ofs[11:2];
		avs_writedata <= d;
		avs_write <= 1'b1;
		wait_ack();
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic bus_read(input logic [11:0] ofs);
		avs_address <= ofs[11:2];
		avs_read <= 1'b1;
		wait_ack();
		avs_read <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wait_state(input hrf_meas_type st);
		int n;
		n = 0;
		while (measurement_state !== st && n < 3000) begin
			@(posedge clk);
			n++;
		end
		check32("measurement_state", {30'h0, st}, {30'h0, measurement_state});
	endtask

	function automatic logic [31:0] dwell_of(input int b, input logic uni);
		if (uni) begin
			return (b == 0) ? 32'h0BAD0000 : 32'h00C0FFEE;
		end
		return 32'h80000000 | b;
	endfunction

	function automatic logic [31:0] hit_of(input int b);
		logic [7:0] v;
		v = b[7:0];
		return {v, 8'h5A, ~v, v};
	endfunction

	// Expected word of the record, built from the field order and sizes
	function automatic logic [31:0] exp_word(input int i, input logic odd, input logic uni);
		int d;
		int h;
		int f;
		d = uni ? 1 : (odd ? 255 : 256);
		h = odd ? 255 : 256;
		f = odd ? 1 : 0;
		if (i == 0) return `HRF_FILE_TYPE;
		if (i == 2) return 32'h0000002A;
		if (i == 3) return 32'h41420000;
		if (i == 67) return {31'h0, odd};
		if (i == 68) return d * 4;
		if (i < 69 + d) return dwell_of(f + i - 69, uni);
		if (i == 69 + d) return h * 4;
		return hit_of(f + i - 70 - d);
	endfunction

	task automatic check_record(input logic odd, input logic uni);
		int total;
		total = 70 + (uni ? 1 : (odd ? 255 : 256)) + (odd ? 255 : 256);
		bus_read(`HRF_OFS_WORDS);
		check32("record_words", total, rd);
		bus_write(`HRF_OFS_PTR, 32'h00000000);
		for (int i = 0; i < total; i++) begin
			bus_read(`HRF_OFS_DATA);
			if (i == 1) begin
				check32("capture_time_in_span", 32'h1, {31'h0, rd >= e0 && rd <= e1});
			end else if (i < 4 || i > 66) begin
				check32("record_word", exp_word(i, odd, uni), rd);
			end
		end
		// Same loop also covers dwell and hit layout
		// Length fields and big-endian order
	endtask

	initial begin
		#(40 * 20000);
		failures++;
		end_of_test();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check32("state_reset", 32'h0, {30'h0, measurement_state});
		bus_read(`HRF_OFS_TIMEOUT);
		check32("timeout_reset", {16'h0000, `HRF_TIMEOUT_RESET}, rd);
		bus_read(12'hFC0);
		check32("unmapped_read", 32'h0, rd);
		bus_read(`HRF_OFS_DATA);
		check32("data_not_ready", 32'h0, rd);
		bus_write(`HRF_OFS_PORT, 32'h0000002A);
		bus_write({`HRF_WIN_ID, 8'h00}, 32'h41420000);
		bus_write({`HRF_WIN_NAME, 8'h00}, 32'h00000000);
		bus_write(`HRF_OFS_EPOCH, 32'h12345678);
		bus_write(`HRF_OFS_TIMEOUT, 32'h00000000);
		bus_write(`HRF_OFS_CONTROL, 32'h00000001);
		check32("clear_pulse", 32'h1, {31'h0, acc_clear});
		check32("capture_enable", 32'h1, {31'h0, acc_capture_enable});
		check32("busy", {30'h0, HRF_MEAS_BUSY}, {30'h0, measurement_state});
		bus_write({`HRF_WIN_NAME, 8'h00}, 32'h4D594E4D);
		check32("name_refused", 32'h1, {31'h0, rejected_write_error});
		bus_read(`HRF_OFS_STATUS);
		check32("status_busy_reject", 32'h00000011, rd);
		bus_write(`HRF_OFS_STATUS, 32'h00000010);
		check32("reject_cleared", 32'h0, {31'h0, rejected_write_error});
		repeat (60) @(posedge clk);
		bus_read(`HRF_OFS_EPOCH);
		e0 = rd;
		bus_write(`HRF_OFS_CONTROL, 32'h00000000);
		wait_state(HRF_MEAS_AVAILABLE);
		bus_read(`HRF_OFS_EPOCH);
		e1 = rd;
		bus_read(`HRF_OFS_STATUS);
		check32("status_even", 32'h00000002, rd);
		bus_read({`HRF_WIN_NAME, 8'h00});
		check32("default_name", `HRF_DEFAULT_PREFIX, rd);
		check_record(1'b0, 1'b0);
		uniform <= 1'b1;
		bus_write({`HRF_WIN_NAME, 8'h00}, 32'h4D594E4D);
		bus_write(`HRF_OFS_CONTROL, 32'h00000002);
		bus_write(`HRF_OFS_TIMEOUT, 32'h00000002);
		bus_read(`HRF_OFS_EPOCH);
		e0 = rd;
		bus_write(`HRF_OFS_CONTROL, 32'h00000003);
		check32("odd_symmetry", 32'h1, {31'h0, acc_odd_symmetry});
		wait_state(HRF_MEAS_AVAILABLE);
		check32("enable_after_timeout", 32'h0, {31'h0, acc_capture_enable});
		bus_read(`HRF_OFS_EPOCH);
		e1 = rd;
		bus_read(`HRF_OFS_STATUS);
		check32("status_uniform", 32'h00000022, rd);
		bus_read({`HRF_WIN_NAME, 8'h00});
		check32("given_name", 32'h4D594E4D, rd);
		check_record(1'b1, 1'b1);
		uniform <= 1'b0;
		bus_write({`HRF_WIN_NAME, 8'h00}, 32'h00000000);
		bus_read(`HRF_OFS_EPOCH);
		e0 = rd;
		bus_write(`HRF_OFS_CONTROL, 32'h00000003);
		wait_state(HRF_MEAS_AVAILABLE);
		bus_read(`HRF_OFS_EPOCH);
		e1 = rd;
		bus_read(`HRF_OFS_STATUS);
		check32("status_odd_varied", 32'h00000002, rd);
		bus_read({`HRF_WIN_NAME, 8'h00});
		check32("default_name_again", `HRF_DEFAULT_PREFIX, rd);
		check_record(1'b1, 1'b0);
		end_of_test();
	end
endmodule
